//--- inc/ide_tf_defs.vh
// task file register bank constants: offsets, field positions, reset values
// included by every design file of the bank; definitions only
`ifndef IDE_TF_DEFS_VH
`define IDE_TF_DEFS_VH
// register selects after decode
`define SEL_DATA 4'h0
`define SEL_ERRFEAT 4'h1
`define SEL_COUNT 4'h2
`define SEL_SECTOR 4'h3
`define SEL_CYLLO 4'h4
`define SEL_CYLHI 4'h5
`define SEL_HEAD 4'h6
`define SEL_STATCMD 4'h7
`define SEL_ALTCTL 4'h8
`define SEL_DRVADDR 4'h9
`define SEL_DMA 4'ha
`define SEL_NONE 4'hf
// alternate block offsets on the second select
`define ALT_STATUS_ADDR 3'h6
`define DRIVE_ADDR_ADDR 3'h7
// error cause bit positions
`define ERR_BAD_BLOCK 7
`define ERR_UNCORR 6
`define ERR_ID_MISSING 4
`define ERR_ABORTED 2
`define ERR_GENERAL 0
// status bit positions
`define ST_BUSY 7
`define ST_READY 6
`define ST_SEEKDONE 4
`define ST_DATAREQ 3
`define ST_ERROR 0
// drive head fields
`define HEAD_LBA_BIT 6
`define HEAD_DRV_BIT 4
// device control fields
`define CTL_SRST_BIT 2
`define CTL_NIEN_BIT 1
// reset values
`define HEAD_RESET 8'ha0
`define COUNT_RESET 8'h01
`define SECTOR_RESET 8'h01
`define ZERO_BYTE 8'h00
// zero count stands for this many sectors
`define FULL_COUNT 9'h100
`define WORDS_LOG 8
`endif

//--- logic/sector_buffer.v
// one-sector word buffer between host data port and card core
// single write port, single read port, read data registered
`timescale 1ns/1ps
`include "ide_tf_defs.vh"
module sector_buffer #(
  parameter WIDTH = 16,
  parameter ADDR_BITS = `WORDS_LOG
) (
  input wire clock,
  input wire wrEn,
  input wire [ADDR_BITS-1:0] wrAddr,
  input wire [WIDTH-1:0] wrData,
  input wire [ADDR_BITS-1:0] rdAddr,
  output reg [WIDTH-1:0] rdData
);
  reg [WIDTH-1:0] mem [0:(1<<ADDR_BITS)-1];

  // no reset on storage; contents undefined until written
  always @(posedge clock)
  begin
    if (wrEn)
      mem[wrAddr] <= wrData;
    rdData <= mem[rdAddr];
  end
endmodule

//--- logic/error_cause_unit.v
// sticky error cause byte and the status error flag
// events are one-cycle pulses from the card core; clear comes with a new command
`timescale 1ns/1ps
`include "ide_tf_defs.vh"
module error_cause_unit (
  input wire clock,
  input wire rst_b,
  input wire clearAll,
  input wire badBlockEvt,
  input wire uncorrEvt,
  input wire idMissingEvt,
  input wire abortEvt,
  input wire generalEvt,
  output reg [7:0] errorCause,
  output reg errorFlag
);
  wire [7:0] setMask;

  // unused bits 5, 3, 1 never get a set term
  assign setMask = {badBlockEvt, uncorrEvt, 1'b0, idMissingEvt, 1'b0, abortEvt, 1'b0, generalEvt};

  // set wins over clear so a late event is kept
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      errorCause <= `ZERO_BYTE;
      errorFlag <= 1'b0;
    end
    else
    begin
      errorCause <= (clearAll ? `ZERO_BYTE : errorCause) | setMask;
      errorFlag <= (clearAll ? 1'b0 : errorFlag) | (|setMask);
    end
  end
endmodule

//--- logic/ide_task_file.v
// task file register bank of the card in its disk-compatible mode
// host pins are synchronous to clock; card core drives busy, events, buffer port
`timescale 1ns/1ps
`include "ide_tf_defs.vh"
// Operation
// - decode CE1, CE2, A2..A0 and DMA acknowledge into register selects
// - sixteen-bit read/write data port moves one sector per sequence
// - data port accepts word accesses and single byte accesses
// - odd byte location reaches error on reads, feature on writes
// - error register read-only, valid only while busy reads zero
// - error bit 7 set on bad block in ID field
// - error bit 6 set on uncorrectable read error
// - error bit 4 set when sector ID wrong or missing
// - error bit 2 set when command aborted by card condition
// - error bit 0 set for general error
// - feature register write-only, byte for the next command
// - sector count for transfer, zero meaning 256
// - unfinished multi-sector transfer leaves remaining sectors in count
// - sector number holds CHS sector or LBA bits 7..0
// - cylinder low holds cylinder low byte or LBA bits 15..8
// - cylinder high holds cylinder high byte or LBA bits 23..16
// - drive head bit 6 selects CHS (0) or LBA (1)
// - status bit 7 busy while internal operation runs
// - failed command sets status bit 0 and error cause
module ide_task_file #(
  parameter ADDR_BITS = `WORDS_LOG
) (
  input wire clock,
  input wire rst_b,
  input wire ce1_b,
  input wire ce2_b,
  input wire [2:0] addr,
  input wire iord_b,
  input wire iowr_b,
  input wire dmack_b,
  input wire byteMode,
  input wire [15:0] dataIn,
  output reg [15:0] dataOut,
  output reg dataOe_b,
  input wire coreBusy,
  input wire coreDataReq,
  input wire coreOwnsBuffer,
  input wire coreWrEn,
  input wire [ADDR_BITS-1:0] coreAddr,
  input wire [15:0] coreWrData,
  output reg [15:0] coreRdData,
  input wire sectorDone,
  input wire badBlockEvt,
  input wire uncorrEvt,
  input wire idMissingEvt,
  input wire abortEvt,
  input wire generalEvt,
  output reg cmdStrobe,
  output reg [7:0] cmdCode,
  output reg [7:0] featureSelect,
  output reg [8:0] sectorsToMove,
  output reg lbaMode,
  output reg [27:0] startAddress,
  output reg driveSelect,
  output reg softReset,
  output reg irqDisable
);
  reg iordPrev;
  reg iowrPrev;
  reg [3:0] readSel;
  reg [7:0] transferSectorCount;
  reg [7:0] startSectorOrLbaLow;
  reg [7:0] cylinderLowOrLbaMid;
  reg [7:0] cylinderHighOrLbaHigh;
  reg [7:0] driveHead;
  reg [ADDR_BITS-1:0] hostPtr;
  reg hostHighByte;
  reg [7:0] lowByteHold;
  reg bufWrEn;
  reg [ADDR_BITS-1:0] bufWrAddr;
  reg [15:0] bufWrData;
  reg [15:0] next_dataOut;
  wire [3:0] sel;
  wire readStart;
  wire readEnd;
  wire writeEnd;
  wire isData;
  wire [15:0] bufRdData;
  wire [7:0] errorCause;
  wire errorFlag;
  wire [7:0] statusByte;
  wire [7:0] driveAddrByte;
  wire cmdWrite;
  wire countWrite;

  // address decode shared by read and write paths
  function [3:0] decodeSel;
    input c1b;
    input c2b;
    input [2:0] a;
    input dmab;
    begin
      if (!dmab && c1b && c2b)
        decodeSel = `SEL_DMA;
      else if (!c1b && c2b && dmab)
        decodeSel = {1'b0, a};
      else if (c1b && !c2b && dmab && a == `ALT_STATUS_ADDR)
        decodeSel = `SEL_ALTCTL;
      else if (c1b && !c2b && dmab && a == `DRIVE_ADDR_ADDR)
        decodeSel = `SEL_DRVADDR;
      else
        decodeSel = `SEL_NONE;
    end
  endfunction

  assign sel = decodeSel(ce1_b, ce2_b, addr, dmack_b);
  assign isData = (sel == `SEL_DATA) || (sel == `SEL_DMA);
  assign readStart = iordPrev && !iord_b;
  assign readEnd = !iordPrev && iord_b;
  assign writeEnd = !iowrPrev && iowr_b;
  // command and register writes are refused while busy; device control and data port writes are not
  assign cmdWrite = writeEnd && sel == `SEL_STATCMD && !coreBusy;
  // accepted host count write this cycle
  // the only write that may override a sector decrement
  assign countWrite = writeEnd && sel == `SEL_COUNT && !coreBusy;

  // busy dominates; error bit from the cause unit
  assign statusByte = {coreBusy, !coreBusy, 1'b0, !coreBusy, coreDataReq && !coreBusy, 2'b00, errorFlag};
  // drive address: inverted head lines, then drive 1 and drive 0 select lines, active high
  assign driveAddrByte = {2'b01, ~driveHead[3:0], driveHead[`HEAD_DRV_BIT], ~driveHead[`HEAD_DRV_BIT]};

  error_cause_unit errors (
    .clock(clock),
    .rst_b(rst_b),
    .clearAll(cmdWrite),
    .badBlockEvt(badBlockEvt),
    .uncorrEvt(uncorrEvt),
    .idMissingEvt(idMissingEvt),
    .abortEvt(abortEvt),
    .generalEvt(generalEvt),
    .errorCause(errorCause),
    .errorFlag(errorFlag)
  );

  // the core owns the read port while it works the buffer
  sector_buffer #(
    .WIDTH(16),
    .ADDR_BITS(ADDR_BITS)
  ) buffer (
    .clock(clock),
    .wrEn(bufWrEn),
    .wrAddr(bufWrAddr),
    .wrData(bufWrData),
    .rdAddr(coreOwnsBuffer ? coreAddr : hostPtr),
    .rdData(bufRdData)
  );

  // buffer write mux: core writes only while it owns the buffer
  always @*
  begin
    bufWrEn = 1'b0;
    bufWrAddr = hostPtr;
    bufWrData = dataIn;
    if (coreOwnsBuffer)
    begin
      bufWrEn = coreWrEn;
      bufWrAddr = coreAddr;
      bufWrData = coreWrData;
    end
    else if (writeEnd && isData)
    begin
      // a byte access completes a word on the high byte
      bufWrEn = !byteMode || hostHighByte;
      bufWrData = byteMode ? {dataIn[7:0], lowByteHold} : dataIn;
    end
  end

  // read data chosen at the falling edge of the read strobe
  always @*
  begin
    next_dataOut = 16'h0000;
    case (sel)
      `SEL_DATA, `SEL_DMA:
      begin
        // byte reads return low byte first, then high byte
        if (byteMode)
          next_dataOut = {8'h00, hostHighByte ? bufRdData[15:8] : bufRdData[7:0]};
        else
          next_dataOut = bufRdData;
      end
      // odd location reads the error cause
      `SEL_ERRFEAT: next_dataOut = {8'h00, errorCause};
      `SEL_COUNT: next_dataOut = {8'h00, transferSectorCount};
      `SEL_SECTOR: next_dataOut = {8'h00, startSectorOrLbaLow};
      `SEL_CYLLO: next_dataOut = {8'h00, cylinderLowOrLbaMid};
      `SEL_CYLHI: next_dataOut = {8'h00, cylinderHighOrLbaHigh};
      `SEL_HEAD: next_dataOut = {8'h00, driveHead};
      `SEL_STATCMD, `SEL_ALTCTL: next_dataOut = {8'h00, statusByte};
      `SEL_DRVADDR: next_dataOut = {8'h00, driveAddrByte};
      default: next_dataOut = 16'h0000;
    endcase
  end

  // strobe history for edge detection
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      iordPrev <= 1'b1;
      iowrPrev <= 1'b1;
    end
    else
    begin
      iordPrev <= iord_b;
      iowrPrev <= iowr_b;
    end
  end

  // host read data path; bus driven only while the strobe is low
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dataOut <= 16'h0000;
      dataOe_b <= 1'b1;
      readSel <= `SEL_NONE;
    end
    else
    begin
      if (readStart && sel != `SEL_NONE)
      begin
        dataOut <= next_dataOut;
        dataOe_b <= 1'b0;
        readSel <= sel;
      end
      else if (iord_b)
      begin
        dataOe_b <= 1'b1;
        readSel <= `SEL_NONE;
      end
    end
  end

  // host buffer pointer and byte lane tracking
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hostPtr <= {ADDR_BITS{1'b0}};
      hostHighByte <= 1'b0;
      lowByteHold <= `ZERO_BYTE;
    end
    else if (cmdWrite || coreOwnsBuffer)
    begin
      // each new command or core phase restarts the sector at word zero
      hostPtr <= {ADDR_BITS{1'b0}};
      hostHighByte <= 1'b0;
    end
    else if ((writeEnd && isData) || (readEnd && (readSel == `SEL_DATA || readSel == `SEL_DMA)))
    begin
      if (writeEnd && byteMode && !hostHighByte)
        lowByteHold <= dataIn[7:0];
      if (byteMode)
        hostHighByte <= !hostHighByte;
      if (!byteMode || hostHighByte)
        hostPtr <= hostPtr + {{(ADDR_BITS-1){1'b0}}, 1'b1};
    end
  end

  // task file registers written at the rising edge of the write strobe
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      featureSelect <= `ZERO_BYTE;
      transferSectorCount <= `COUNT_RESET;
      startSectorOrLbaLow <= `SECTOR_RESET;
      cylinderLowOrLbaMid <= `ZERO_BYTE;
      cylinderHighOrLbaHigh <= `ZERO_BYTE;
      driveHead <= `HEAD_RESET;
      cmdCode <= `ZERO_BYTE;
      cmdStrobe <= 1'b0;
      softReset <= 1'b0;
      irqDisable <= 1'b0;
    end
    else
    begin
      cmdStrobe <= cmdWrite;
      if (cmdWrite)
        cmdCode <= dataIn[7:0];
      // device control stays writable while busy so a soft reset can land
      if (writeEnd && sel == `SEL_ALTCTL)
      begin
        softReset <= dataIn[`CTL_SRST_BIT];
        irqDisable <= dataIn[`CTL_NIEN_BIT];
      end
      if (writeEnd && !coreBusy)
      begin
        case (sel)
          // odd location write is the feature byte
          `SEL_ERRFEAT: featureSelect <= dataIn[7:0];
          // count written as is, zero kept as zero
          `SEL_COUNT: transferSectorCount <= dataIn[7:0];
          `SEL_SECTOR: startSectorOrLbaLow <= dataIn[7:0];
          // cylinder low or middle address byte
          `SEL_CYLLO: cylinderLowOrLbaMid <= dataIn[7:0];
          // cylinder high or upper address byte
          `SEL_CYLHI: cylinderHighOrLbaHigh <= dataIn[7:0];
          `SEL_HEAD: driveHead <= dataIn[7:0];
          default: driveHead <= driveHead;
        endcase
      end
      // each finished sector leaves the remainder in the count
      // a write elsewhere, or one refused while busy, must not eat it
      // only a count write in the same cycle wins over the decrement
      if (sectorDone && !countWrite)
        transferSectorCount <= transferSectorCount - 8'h01;
    end
  end

  // registered views of the task file for the card core
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sectorsToMove <= `FULL_COUNT;
      lbaMode <= 1'b0;
      startAddress <= 28'h0000000;
      driveSelect <= 1'b0;
      coreRdData <= 16'h0000;
    end
    else
    begin
      // zero count means a full 256 sectors
      sectorsToMove <= (transferSectorCount == `ZERO_BYTE) ? `FULL_COUNT : {1'b0, transferSectorCount};
      // addressing mode from drive head bit 6
      lbaMode <= driveHead[`HEAD_LBA_BIT];
      startAddress <= {driveHead[3:0], cylinderHighOrLbaHigh, cylinderLowOrLbaMid, startSectorOrLbaLow};
      driveSelect <= driveHead[`HEAD_DRV_BIT];
      coreRdData <= bufRdData;
    end
  end
endmodule

//--- tb/ide_task_file_sva.sv
// checker for the task file bank, watching top-level ports only
// assumes host pins are synchronous to clock, as the bank samples them
`timescale 1ns/1ps
module ide_task_file_chk (
  input logic clock,
  input logic rst_b,
  input logic ce1_b,
  input logic ce2_b,
  input logic [2:0] addr,
  input logic iord_b,
  input logic iowr_b,
  input logic dmack_b,
  input logic [15:0] dataIn,
  input logic [15:0] dataOut,
  input logic dataOe_b,
  input logic coreBusy,
  input logic sectorDone,
  input logic [8:0] sectorsToMove,
  input logic lbaMode,
  input logic [27:0] startAddress
);
  logic wrLast;
  logic [7:0] lastByte;
  wire wrTake = iowr_b && !wrLast && !ce1_b && ce2_b && !coreBusy;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // last write byte, kept so a late output can be tied to it
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wrLast <= 1'b1;
      lastByte <= 8'h00;
    end
    else
    begin
      wrLast <= iowr_b;
      lastByte <= iowr_b && !wrLast ? dataIn[7:0] : lastByte;
    end
  end
  chk_oe_drive: assert property ($fell(iord_b) && !ce1_b && ce2_b && dmack_b |=> !dataOe_b)
    else $error("bus not driven on selected read");
  chk_oe_idle: assert property ($fell(iord_b) && ce1_b && ce2_b && dmack_b |=> dataOe_b[*2])
    else $error("bus driven while unselected");
  chk_err_zeros: assert property ($fell(iord_b) && !ce1_b && ce2_b && dmack_b && addr == 3'h1 |=>
    (dataOut & 16'hff2a) == 16'h0000)
    else $error("error byte reserved bits set");
  chk_count_full: assert property (wrTake && addr == 3'h2 |-> ##3 sectorsToMove == (lastByte == 8'h00 ? 9'h100 : {1'b0, lastByte}))
    else $error("sector count wrong");
  chk_count_step: assert property (sectorDone && iowr_b && wrLast |-> ##2
    sectorsToMove == ($past(sectorsToMove) == 9'h001 ? 9'h100 : $past(sectorsToMove) - 9'h001))
    else $error("count not decremented");
  chk_sector_byte: assert property (wrTake && addr == 3'h3 |-> ##3 startAddress[7:0] == lastByte)
    else $error("sector byte wrong");
  chk_cyl_low: assert property (wrTake && addr == 3'h4 |-> ##3 startAddress[15:8] == lastByte)
    else $error("cylinder low wrong");
  chk_cyl_high: assert property (wrTake && addr == 3'h5 |-> ##3 startAddress[23:16] == lastByte)
    else $error("cylinder high wrong");
  chk_lba_mode: assert property (wrTake && addr == 3'h6 |-> ##3 lbaMode == lastByte[6])
    else $error("addressing mode wrong");
endmodule
bind ide_task_file ide_task_file_chk chk_u (.clock, .rst_b, .ce1_b, .ce2_b, .addr, .iord_b, .iowr_b, .dmack_b,
  .dataIn, .dataOut, .dataOe_b, .coreBusy, .sectorDone, .sectorsToMove, .lbaMode, .startAddress);

//--- tb/ata_host_model.sv
// host controller model driving the task file pins
// assumes the card samples every pin on the rising clock edge
`timescale 1ns/1ps
module ata_host_model (
  input wire clock,
  output logic ce1_b,
  output logic ce2_b,
  output logic [2:0] addr,
  output logic iord_b,
  output logic iowr_b,
  output logic dmack_b,
  output logic [15:0] dataIn
);
  // idle bus: nothing selected, no strobe
  initial
  begin
    {dmack_b, ce2_b, ce1_b, iord_b, iowr_b} = 5'h1f;
    addr = 3'h0;
    dataIn = 16'h0000;
  end
  // one access; sel is {dmack_b, ce2_b, ce1_b}
  // selects held past taking edge
  task automatic acc(input bit rd, input logic [2:0] sel, input logic [2:0] a, input logic [15:0] d);
    @(negedge clock);
    {dmack_b, ce2_b, ce1_b} = sel;
    addr = a;
    dataIn = d;
    iord_b = ~rd;
    iowr_b = rd;
    repeat (2) @(negedge clock);
    iord_b = 1'b1;
    iowr_b = 1'b1;
    repeat (2) @(negedge clock);
    {dmack_b, ce2_b, ce1_b} = 3'b111;
    // released lines must not keep the old word
    dataIn = ~d;
    repeat (2) @(negedge clock);
  endtask
endmodule

//--- tb/tb_ide_task_file.sv
// self-checking bench for the task file bank
// host model drives the pins; bench plays the card core
`timescale 1ns/1ps
module tb_ide_task_file;
  logic clock, rst_b, ce1_b, ce2_b, iord_b, iowr_b, dmack_b, byteMode, dataOe_b;
  logic coreBusy, coreOwnsBuffer, coreWrEn, sectorDone, coreDataReq;
  logic cmdStrobe, driveSelect, softReset, irqDisable;
  logic [7:0] cmdCode;
  logic [15:0] coreRdData;
  logic [2:0] addr;
  logic [4:0] evt;
  logic [7:0] coreAddr, featureSelect;
  logic [15:0] dataIn, dataOut, coreWrData, w0, w1, v;
  logic [8:0] sectorsToMove;
  logic lbaMode, oeLast;
  logic [27:0] startAddress;
  logic [31:0] expQ[$];
  logic [7:0] rv [2:6] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'ha0};
  logic [7:0] eb [0:4] = '{8'h80, 8'h40, 8'h10, 8'h04, 8'h01};
  integer failCount = 0, compares = 0, cmdCount = 0, seed, i;
  ata_host_model host_u (.clock(clock), .ce1_b(ce1_b), .ce2_b(ce2_b), .addr(addr), .iord_b(iord_b),
    .iowr_b(iowr_b), .dmack_b(dmack_b), .dataIn(dataIn));
  ide_task_file dut_u (.clock(clock), .rst_b(rst_b), .ce1_b(ce1_b), .ce2_b(ce2_b), .addr(addr),
    .iord_b(iord_b), .iowr_b(iowr_b), .dmack_b(dmack_b), .byteMode(byteMode), .dataIn(dataIn),
    .dataOut(dataOut), .dataOe_b(dataOe_b), .coreBusy(coreBusy), .coreDataReq(coreDataReq),
    .coreOwnsBuffer(coreOwnsBuffer), .coreWrEn(coreWrEn), .coreAddr(coreAddr), .coreWrData(coreWrData),
    .coreRdData(coreRdData), .sectorDone(sectorDone), .badBlockEvt(evt[0]), .uncorrEvt(evt[1]),
    .idMissingEvt(evt[2]), .abortEvt(evt[3]), .generalEvt(evt[4]), .cmdStrobe(cmdStrobe), .cmdCode(cmdCode),
    .featureSelect(featureSelect), .sectorsToMove(sectorsToMove), .lbaMode(lbaMode),
    .startAddress(startAddress), .driveSelect(driveSelect), .softReset(softReset), .irqDisable(irqDisable));
  // free-running clock
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failCount++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("compares %0d mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task wr(input logic [2:0] a, input logic [15:0] d);
    host_u.acc(1'b0, 3'b110, a, d);
  endtask
  // note is {mask, expected}, taken by the monitor
  task rd(input logic [2:0] sel, input logic [2:0] a, input logic [15:0] m, input logic [15:0] e);
    expQ.push_back({m, e});
    host_u.acc(1'b1, sel, a, 16'h0000);
  endtask
  task pulse(input bit done, input logic [4:0] e);
    @(negedge clock);
    sectorDone = done;
    evt = e;
    @(negedge clock);
    sectorDone = 1'b0;
    evt = 5'h00;
  endtask
  // read answers compared once the bus is driven
  always @(negedge clock)
  begin : mon
    logic [31:0] note;
    if (!dataOe_b && oeLast)
    begin
      note = expQ.pop_front();
      check(dataOut & note[31:16], note[15:0]);
    end
    oeLast = dataOe_b;
  end
  // accepted commands counted by their one-cycle strobe
  always @(negedge clock)
    if (cmdStrobe)
      cmdCount++;
  // bounded run; a hang counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge clock);
    failCount++;
    print_verdict;
  end
  initial
  begin
    seed = 25;
    {coreDataReq, coreBusy, coreOwnsBuffer, coreWrEn, sectorDone, byteMode, rst_b, oeLast} = 8'h01;
    evt = 5'h00;
    coreAddr = 8'h00;
    coreWrData = 16'h0000;
    repeat (8) @(posedge clock);
    @(negedge clock);
    check({7'h00, sectorsToMove}, 16'h0100);
    rst_b = 1'b1;
    @(negedge clock);
    check({7'h00, sectorsToMove}, 16'h0001);
    for (i = 2; i < 7; i++)
      rd(3'b110, i, 16'hffff, {8'h00, rv[i]});
    for (i = 2; i < 7; i++)
    begin
      v = $random(seed);
      wr(i, v);
      rd(3'b110, i, 16'hffff, {8'h00, v[7:0]});
    end
    check({10'h000, lbaMode, driveSelect, startAddress[27:24]}, {10'h000, v[6], v[4], v[3:0]});
    wr(2, 16'h0000);
    rd(3'b110, 2, 16'hffff, 16'h0000);
    check({7'h00, sectorsToMove}, 16'h0100);
    wr(2, 16'h0005);
    pulse(1'b1, 5'h00);
    rd(3'b110, 2, 16'hffff, 16'h0004);
    $display("task file registers done");
    wr(3, 16'h0011);
    coreBusy = 1'b1;
    wr(3, 16'h0022);
    wr(7, 16'h00ec);
    host_u.acc(1'b0, 3'b101, 3'h6, 16'h000e);
    check({14'h0000, softReset, irqDisable}, 16'h0003);
    rd(3'b101, 6, 16'h0080, 16'h0080);
    coreBusy = 1'b0;
    rd(3'b110, 3, 16'hffff, 16'h0011);
    host_u.acc(1'b1, 3'b111, 3'h0, 16'h0000);
    $display("busy refusal done");
    coreDataReq = 1'b1;
    for (i = 0; i < 5; i++)
    begin
      wr(7, 16'h0020 + i);
      pulse(1'b0, 5'h01 << i);
      rd(3'b110, 1, 16'hffff, {8'h00, eb[i]});
      rd(3'b110, 7, 16'hffff, 16'h0059);
    end
    coreDataReq = 1'b0;
    wr(7, 16'h00c4);
    rd(3'b110, 1, 16'hffff, 16'h0000);
    check({8'h00, cmdCode}, 16'h00c4);
    wr(1, 16'h005a);
    check({8'h00, featureSelect}, 16'h005a);
    $display("error causes done");
    w0 = $random(seed);
    w1 = $random(seed);
    @(negedge clock);
    {coreOwnsBuffer, coreWrEn, coreWrData} = {2'b11, w0};
    @(negedge clock);
    {coreAddr, coreWrData} = {8'h01, w1};
    @(negedge clock);
    {coreOwnsBuffer, coreWrEn} = 2'b00;
    rd(3'b110, 0, 16'hffff, w0);
    byteMode = 1'b1;
    rd(3'b110, 0, 16'hffff, {8'h00, w1[7:0]});
    rd(3'b110, 0, 16'hffff, {8'h00, w1[15:8]});
    rd(3'b110, 1, 16'hffff, 16'h0000);
    byteMode = 1'b0;
    {coreOwnsBuffer, coreAddr} = {1'b1, 8'h01};
    repeat (3) @(negedge clock);
    check(coreRdData, w1);
    coreOwnsBuffer = 1'b0;
    rd(3'b011, 0, 16'hffff, w0);
    byteMode = 1'b1;
    wr(0, {8'h00, w0[15:8]});
    wr(1, 16'h00a5);
    wr(0, {8'h00, w0[7:0]});
    byteMode = 1'b0;
    check({8'h00, featureSelect}, 16'h00a5);
    {coreOwnsBuffer, coreAddr} = {1'b1, 8'h01};
    repeat (3) @(negedge clock);
    check(coreRdData, {w0[7:0], w0[15:8]});
    coreOwnsBuffer = 1'b0;
    $display("data port done");
    check(expQ.size(), 16'h0000);
    check(cmdCount, 16'h0006);
    print_verdict;
  end
endmodule
